// ==== fgpio_pkg.sv ====
// package: constants and carriers for the fast gpio port block
package fgpio_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int          FGPIO_W        = 32;
    localparam int          FGPIO_LANES    = 4;
    localparam logic [31:0] FGPIO_DIR_RST  = 32'h0000_0000;
    localparam logic [31:0] FGPIO_OUT_RST  = 32'h0000_0000;
    localparam logic [31:0] FGPIO_MASK_RST = 32'h0000_0000;
    localparam logic [31:0] FGPIO_EN_RST   = 32'h0000_0000;

    // ------------------------------------------------------------
    // register offsets (word-aligned byte addresses)
    // ------------------------------------------------------------
    localparam logic [4:0] FGPIO_OFS_DIR  = 5'h00;
    localparam logic [4:0] FGPIO_OFS_MASK = 5'h04;
    localparam logic [4:0] FGPIO_OFS_PIN  = 5'h08;
    localparam logic [4:0] FGPIO_OFS_SET  = 5'h0C;
    localparam logic [4:0] FGPIO_OFS_CLR  = 5'h10;
    localparam logic [4:0] FGPIO_OFS_RISE = 5'h14;
    localparam logic [4:0] FGPIO_OFS_FALL = 5'h18;
    localparam logic [4:0] FGPIO_OFS_STAT = 5'h1C;

    // ------------------------------------------------------------
    // register access request carrier
    // ------------------------------------------------------------
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [4:0]  addr;
        logic [3:0]  be;
        logic [31:0] wdata;
    } fgpio_req_s;

endpackage : fgpio_pkg

// ==== fgpio_edge_cell.sv ====
// file: clockless edge catcher for one pin
`timescale 1ns/1ps

module fgpio_edge_cell
    import fgpio_pkg::*;
(
    input  wire logic pin,
    input  wire logic rise_en,
    input  wire logic fall_en,
    input  wire logic clr,
    input  wire logic arst_n,
    output logic      flag
);
    logic rise_hit;
    logic fall_hit;
    logic clr_n;

    assign clr_n = arst_n & ~clr;

    // the pin itself clocks the catchers, so no system clock is needed
    always_ff @(posedge pin or negedge clr_n)
    begin
        if (!clr_n)
            rise_hit <= 1'b0;
        else if (rise_en)
            rise_hit <= 1'b1;
    end

    always_ff @(negedge pin or negedge clr_n)
    begin
        if (!clr_n)
            fall_hit <= 1'b0;
        else if (fall_en)
            fall_hit <= 1'b1;
    end

    assign flag = rise_hit | fall_hit;

endmodule : fgpio_edge_cell

// ==== fgpio_port.sv ====
// file: fast gpio port with per-pin edge interrupt and wake request
// Contract
// - pins without a peripheral are driven and sampled by these registers
// - per-pin direction bit selects input or driven output, anytime
// - set and clear registers change only bits written as one
// - output latch and live pin level are both readable
// - mask blocks value, set and clear writes to masked bits and reads them as zero from the pin register
// - byte and half-word accesses touch only addressed lanes
// - one write to the value register updates the whole port
// - each pin flags rising, falling or both edges as enabled
// - edge detection works without a running clock
// - any enabled edge flag raises a wake-up request
// - after reset all direction bits select input
`timescale 1ns/1ps

module fgpio_port
    import fgpio_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire fgpio_req_s        req,
    output logic [FGPIO_W-1:0]     rdata,
    output logic                   rvalid,
    input  wire logic              periph_sel_n_all,
    input  wire logic [FGPIO_W-1:0] periph_sel,
    input  wire logic [FGPIO_W-1:0] periph_out,
    input  wire logic [FGPIO_W-1:0] periph_oe,
    input  wire logic [FGPIO_W-1:0] pin_i,
    output logic [FGPIO_W-1:0]     pin_o,
    output logic [FGPIO_W-1:0]     pin_oe,
    output logic [FGPIO_W-1:0]     edge_flags,
    output logic                   irq,
    output logic                   wake_req
);
    // ------------------------------------------------------------
    // storage
    // ------------------------------------------------------------
    logic [FGPIO_W-1:0] dir_q;
    logic [FGPIO_W-1:0] out_q;
    logic [FGPIO_W-1:0] mask_q;
    logic [FGPIO_W-1:0] rise_en_q;
    logic [FGPIO_W-1:0] fall_en_q;
    logic [FGPIO_W-1:0] clr_q;
    logic [FGPIO_W-1:0] lane_m;
    logic [FGPIO_W-1:0] wr_m;
    logic [FGPIO_W-1:0] sel_m;
    logic               wr_dir;
    logic               wr_mask;
    logic               wr_pin;
    logic               wr_set;
    logic               wr_clr;
    logic               wr_rise;
    logic               wr_fall;
    logic               wr_stat;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    // byte enables expand into a bit mask
    always_comb
    begin
        for (int i = 0; i < FGPIO_LANES; i++)
            lane_m[i*8 +: 8] = {8{req.be[i]}};
    end

    assign wr_m    = lane_m & ~mask_q;
    assign wr_dir  = req.wr && req.addr == FGPIO_OFS_DIR;
    assign wr_mask = req.wr && req.addr == FGPIO_OFS_MASK;
    assign wr_pin  = req.wr && req.addr == FGPIO_OFS_PIN;
    assign wr_set  = req.wr && req.addr == FGPIO_OFS_SET;
    assign wr_clr  = req.wr && req.addr == FGPIO_OFS_CLR;
    assign wr_rise = req.wr && req.addr == FGPIO_OFS_RISE;
    assign wr_fall = req.wr && req.addr == FGPIO_OFS_FALL;
    assign wr_stat = req.wr && req.addr == FGPIO_OFS_STAT;

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    // direction, resets to all inputs
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            dir_q <= FGPIO_DIR_RST;
        else if (wr_dir)
            dir_q <= (dir_q & ~lane_m) | (req.wdata & lane_m);
    end

    // mask
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            mask_q <= FGPIO_MASK_RST;
        else if (wr_mask)
            mask_q <= (mask_q & ~lane_m) | (req.wdata & lane_m);
    end

    // output latch: value write, set and clear
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            out_q <= FGPIO_OUT_RST;
        else if (wr_pin)
            out_q <= (out_q & ~wr_m) | (req.wdata & wr_m);
        else if (wr_set)
            out_q <= out_q | (req.wdata & wr_m);
        else if (wr_clr)
            out_q <= out_q & ~(req.wdata & wr_m);
    end

    // edge enables
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rise_en_q <= FGPIO_EN_RST;
            fall_en_q <= FGPIO_EN_RST;
        end
        else
        begin
            if (wr_rise)
                rise_en_q <= (rise_en_q & ~lane_m) | (req.wdata & lane_m);
            if (wr_fall)
                fall_en_q <= (fall_en_q & ~lane_m) | (req.wdata & lane_m);
        end
    end

    // write-one-to-clear pulse for edge flags, held one cycle
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            clr_q <= '0;
        else if (wr_stat)
            clr_q <= req.wdata & lane_m;
        else
            clr_q <= '0;
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    // peripheral owns a pin when selected, otherwise this port does
    assign sel_m  = periph_sel & {FGPIO_W{~periph_sel_n_all}};
    assign pin_o  = (sel_m & periph_out) | (~sel_m & out_q);
    assign pin_oe = (sel_m & periph_oe) | (~sel_m & dir_q);

    // ------------------------------------------------------------
    // edge detection
    // ------------------------------------------------------------
    for (genvar g = 0; g < FGPIO_W; g++)
    begin : g_edge
        fgpio_edge_cell u_cell (
            .pin     (pin_i[g]),
            .rise_en (rise_en_q[g]),
            .fall_en (fall_en_q[g]),
            .clr     (clr_q[g]),
            .arst_n  (arst_n),
            .flag    (edge_flags[g])
        );
    end

    assign irq      = |edge_flags;
    assign wake_req = |edge_flags;

    // ------------------------------------------------------------
    // read path
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rdata  <= '0;
            rvalid <= 1'b0;
        end
        else
        begin
            rvalid <= req.rd;
            if (req.rd)
            begin
                unique case (req.addr)
                    FGPIO_OFS_DIR:  rdata <= dir_q & lane_m;
                    FGPIO_OFS_MASK: rdata <= mask_q & lane_m;
                    FGPIO_OFS_PIN:  rdata <= pin_i & ~mask_q & lane_m;
                    FGPIO_OFS_SET:  rdata <= out_q & lane_m;
                    FGPIO_OFS_RISE: rdata <= rise_en_q & lane_m;
                    FGPIO_OFS_FALL: rdata <= fall_en_q & lane_m;
                    FGPIO_OFS_STAT: rdata <= edge_flags & lane_m;
                    default:        rdata <= '0;
                endcase
            end
        end
    end

endmodule : fgpio_port

// ==== fgpio_port_checker.sv ====
// checker: port assertions for fgpio_port
`timescale 1ns/1ps
module fgpio_port_checker
    import fgpio_pkg::*;
(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire fgpio_req_s  req,
    input wire logic [31:0] rdata,
    input wire logic        rvalid,
    input wire logic        periph_sel_n_all,
    input wire logic [31:0] periph_sel,
    input wire logic [31:0] periph_out,
    input wire logic [31:0] periph_oe,
    input wire logic [31:0] pin_i,
    input wire logic [31:0] pin_o,
    input wire logic [31:0] pin_oe,
    input wire logic [31:0] edge_flags,
    input wire logic        irq,
    input wire logic        wake_req
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // decoded writes
    // ------------------------------------------------------------
    logic dw;
    logic sw;
    logic sa;

    // direction write, status write, status write clearing all
    assign dw = req.wr && req.addr == FGPIO_OFS_DIR && periph_sel_n_all;
    assign sw = req.wr && req.addr == FGPIO_OFS_STAT;
    assign sa = sw && req.be == 4'hF && req.wdata == 32'hFFFF_FFFF;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    read_ans_a: assert property (
        req.rd |=> rvalid)
        else $error("read not answered");
    read_hold_a: assert property (
        !req.rd |=> !rvalid && $stable(rdata))
        else $error("read data moved");
    dir_word_a: assert property (
        dw && req.be == 4'hF ##1 periph_sel_n_all
        |-> pin_oe == $past(req.wdata))
        else $error("direction write");
    dir_lane_a: assert property (
        dw && req.be == 4'h1 ##1 periph_sel_n_all
        |-> pin_oe == {$past(pin_oe[31:8]), $past(req.wdata[7:0])})
        else $error("byte direction write");
    dir_reset_a: assert property (
        periph_sel_n_all && !$past(arst_n) |-> pin_oe == 32'h0)
        else $error("pin driven after reset");
    flag_hold_a: assert property (
        !sw && !$past(sw)
        |=> (edge_flags & $past(edge_flags)) == $past(edge_flags))
        else $error("edge flag lost");
    flag_clear_a: assert property (
        sa |=> edge_flags == 32'h0)
        else $error("edge flags not cleared");
    irq_or_a: assert property (irq == |edge_flags)
        else $error("irq not or of flags");
    wake_irq_a: assert property (wake_req == irq)
        else $error("wake differs from irq");
    periph_oe_a: assert property (
        !periph_sel_n_all
        |-> ((pin_oe ^ periph_oe) & periph_sel) == 32'h0)
        else $error("peripheral enable");

    // ------------------------------------------------------------
    // main scenarios reached
    // ------------------------------------------------------------
    cover property (dw ##1 periph_sel_n_all);
    cover property ($rose(irq));
    cover property (sa);
    cover property (!periph_sel_n_all);
endmodule : fgpio_port_checker

// ==== fgpio_board.sv ====
// board model: pin levels seen by the port
`timescale 1ns/1ps
module fgpio_board
(
    input  wire logic [31:0] pin_o,
    input  wire logic [31:0] pin_oe,
    input  wire logic [31:0] ext,
    output logic      [31:0] pin_i
);
    // driven pins read back the port value, others the board level
    assign pin_i = (pin_o & pin_oe) | (ext & ~pin_oe);
endmodule : fgpio_board

// ==== fgpio_port_bench.sv ====
// bench: random and corner tests of fgpio_port
`timescale 1ns/1ps
module fgpio_port_bench
    import fgpio_pkg::*;
;
    logic        clk, rvalid, irq, wake_req;
    logic        arst_n = 1'b1, periph_sel_n_all = 1'b1;
    fgpio_req_s  req = '0;
    logic [31:0] periph_sel = 32'h0, periph_out = 32'h0, periph_oe = 32'h0;
    logic [31:0] ext = 32'h0, d_q = 32'h0, m_q = 32'h0, o_q = 32'h0;
    logic [31:0] rdata, pin_i, pin_o, pin_oe, edge_flags, v, l;
    logic [3:0]  be;
    int          fail_count = 0, compares = 0, seed = 32'hF633E908;

    fgpio_port dut_u (.clk, .arst_n, .req, .rdata, .rvalid, .periph_sel_n_all,
        .periph_sel, .periph_out, .periph_oe, .pin_i, .pin_o, .pin_oe,
        .edge_flags, .irq, .wake_req);
    fgpio_board board_u (.pin_o, .pin_oe, .ext, .pin_i);

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp)
        begin
            fail_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [4:0] a, input logic [3:0] b,
                      input logic [31:0] d);
        @(posedge clk) req <= '{1'b1, 1'b0, a, b, d};
        @(posedge clk) req <= '0;
    endtask : wr

    task automatic rd(input logic [4:0] a, input logic [31:0] exp);
        @(posedge clk) req <= '{1'b0, 1'b1, a, 4'hF, 32'h0};
        @(posedge clk) req <= '0;
        #1 chk({31'h0, rvalid}, 32'h1);
        chk(rdata, exp);
    endtask : rd

    function automatic logic [31:0] lanes(input logic [3:0] b);
        return {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    endfunction : lanes

    // live pin level as read through the mask
    function automatic logic [31:0] exp_pins(input logic [31:0] o,
        input logic [31:0] d, input logic [31:0] e, input logic [31:0] m);
        return ((o & d) | (e & ~d)) & ~m;
    endfunction : exp_pins

    task automatic summarize;
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : summarize

    // random register traffic, mid-run reset, edge and peripheral corners
    initial
    begin
        arst_n <= 1'b0;
        repeat (3) @(posedge clk);
        arst_n <= 1'b1;
        #1 chk(pin_oe, 32'h0);
        rd(FGPIO_OFS_DIR, 32'h0);
        for (int i = 0; i < 60; i++)
        begin
            v = $random(seed);
            be = (i < 5) ? 4'hF : (i < 10) ? 4'h1 : 4'($random(seed));
            l = lanes(be);
            wr(5'(4 * (i % 5)), be, v);
            ext <= $random(seed);
            case (i % 5)
                0: d_q = (d_q & ~l) | (v & l);
                1: m_q = (m_q & ~l) | (v & l);
                2: o_q = (o_q & ~(l & ~m_q)) | (v & l & ~m_q);
                3: o_q = o_q | (v & l & ~m_q);
                default: o_q = o_q & ~(v & l & ~m_q);
            endcase
            rd(FGPIO_OFS_SET, o_q);
            rd(FGPIO_OFS_PIN, exp_pins(o_q, d_q, ext, m_q));
            rd(FGPIO_OFS_DIR, d_q);
            chk(pin_oe, d_q);
            chk(pin_o, o_q);
        end
        // reset in mid-run drops every driven pin at once
        @(posedge clk) arst_n <= 1'b0;
        #1 chk(pin_oe, 32'h0);
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        rd(FGPIO_OFS_DIR, 32'h0);
        rd(FGPIO_OFS_SET, 32'h0);
        // edges seen at once, before any clock edge follows them
        wr(FGPIO_OFS_DIR, 4'hF, 32'h0);
        ext <= 32'h0;
        wr(FGPIO_OFS_RISE, 4'hF, 32'h5);
        wr(FGPIO_OFS_FALL, 4'hF, 32'h6);
        @(posedge clk) ext <= 32'hF;
        #1 chk(edge_flags, 32'h5);
        @(posedge clk) #1 chk(edge_flags, 32'h5);
        chk({31'h0, irq}, 32'h1);
        chk({31'h0, wake_req}, 32'h1);
        rd(FGPIO_OFS_STAT, 32'h5);
        wr(FGPIO_OFS_STAT, 4'hF, 32'hFFFFFFFF);
        repeat (2) @(posedge clk);
        #1 chk(edge_flags, 32'h0);
        chk({31'h0, irq}, 32'h0);
        chk({31'h0, wake_req}, 32'h0);
        @(posedge clk) ext <= 32'h0;
        #1 chk(edge_flags, 32'h6);
        @(posedge clk) #1 chk(edge_flags, 32'h6);
        wr(FGPIO_OFS_STAT, 4'h1, 32'h2);
        @(posedge clk) #1 chk(edge_flags, 32'h4);
        @(posedge clk) periph_sel_n_all <= 1'b0;
        periph_sel <= $random(seed);
        periph_out <= $random(seed);
        periph_oe <= $random(seed);
        @(posedge clk) #1 chk(pin_oe, periph_oe & periph_sel);
        chk(pin_o & periph_sel, periph_out & periph_sel);
        summarize();
    end

    // hang guard
    initial
    begin
        #2000000;
        fail_count++;
        summarize();
    end
endmodule : fgpio_port_bench

bind fgpio_port fgpio_port_checker chk_u (.clk, .arst_n, .req, .rdata,
    .rvalid, .periph_sel_n_all, .periph_sel, .periph_out, .periph_oe, .pin_i,
    .pin_o, .pin_oe, .edge_flags, .irq, .wake_req);
